/* logic/sfpp_device.sv */
// Device-side pin front end of the serial flash: framing, hold, protection, buffering.
//
// Summary of operation
// R1: Output changes on serial clock falling edges.
// R2: Dual program takes two bits per rising edge.
// R3: Output released whenever chip select is high.
// R4: Write-protect low engages hardware sector lock.
// R5: Floating write-protect reads as deasserted.
// R6: Hold ignores clock and input, floats output.
// R7: Hold pauses only; frame state is kept.
// R8: Host asserts hold only with clock low.
// R9: Self-timed operations continue through hold.
// R10: Floating hold reads as deasserted.
// R11: Four erase sizes, largest is full chip.
// R12: Protected sectors refuse program and erase.
// R13: D8h/52h/20h erase 64K/32K/4K blocks.
// R14: 02h programs up to 256 bytes, one page.
// R15: Protection uses 64 KB sectors, zero upward.
// R16: Input captured on serial clock rising edges.
// R17: Commands framed between chip select edges.
// R18: 24-bit addresses, block offset bits ignored.
`timescale 1ns/1ps
`default_nettype none
module sfpp_device
  import sfpp_pkg::*;
#(
  parameter int BUSY_CYCLES = 64
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         cs_n,
  input  wire logic         sck,
  input  wire logic         si,
  input  wire logic         so_in,
  output logic              so_out,
  output logic              so_oe_n,
  input  wire logic         wp_n,
  input  wire logic         hold_n,
  input  wire logic [63:0]  sector_protect,
  input  wire logic [7:0]   read_data,
  output sfpp_req_type      req,
  output logic              req_valid,
  output logic              req_refused,
  output sfpp_word_type     word,
  output logic              word_valid,
  input  wire logic         word_ready,
  output logic              busy
);

  // The busy timer is sixteen bits wide, so longer self-timed operations cannot be served.
  if (BUSY_CYCLES < 1 || BUSY_CYCLES > 65535) begin : g_bad_busy
    $error("BUSY_CYCLES out of range.");
  end

  // Whole module state in one packed struct.
  typedef struct packed {
    logic [1:0]     cs_s, sck_s, si_s, so_s, wp_s, hold_s;
    logic           sck_prev;
    sfpp_state_type st;
    logic [5:0]     bits;
    logic [7:0]     opc;
    logic [23:0]    addr;
    logic [7:0]     sh;
    logic [7:0]     out_sh;
    logic           dual;
    logic           prot_ok;
    sfpp_kind_type  kind;
    sfpp_word_type  [1:0] fifo;
    logic [1:0]     wptr, rptr;
    logic [1:0]     count;
    logic           so_out, so_oe_n;
    logic           out_on;
    sfpp_req_type   req;
    logic           req_valid, req_refused;
    sfpp_word_type  word;
    logic           word_valid;
    logic [15:0]    busy_cnt;
    logic           busy;
  } sfpp_dev_state_type;

  sfpp_dev_state_type s_q, s_d;

  // Sector number of an address; protection works at 64 KB grain.
  function automatic logic [5:0] sector_of(input logic [23:0] a);
    // Address bits above the last sector are ignored rather than wrapped into the index.
    return a[SFPP_SECTOR_LSB +: $clog2(SFPP_SECTORS)]; // R15
  endfunction

  // Aligns an address down to a power-of-two block boundary.
  function automatic logic [23:0] align(input logic [23:0] a, input int lsb);
    return (a >> lsb) << lsb; // R18
  endfunction

  logic cs_act, hold_act, rise, fall, wp_act;
  assign cs_act   = ~s_q.cs_s[1];
  // Pull-ups are modelled by the pad; an open pin arrives here high.
  assign hold_act = ~s_q.hold_s[1]; // R10
  assign wp_act   = ~s_q.wp_s[1];   // R4 R5
  // Edges are found on the synchronised clock only, and are ignored in hold.
  assign rise = s_q.sck_s[1] & ~s_q.sck_prev & cs_act & ~hold_act; // R6 R16
  assign fall = ~s_q.sck_s[1] & s_q.sck_prev & cs_act & ~hold_act; // R1 R6

  // Next-state logic for framing, output, buffer and busy timer.
  always_comb begin
    logic        bitv, pushw, popw;
    logic [23:0] full_addr;
    logic [8:0]  nbits;
    sfpp_word_type nw;
    s_d = s_q;
    bitv = 1'b0;
    pushw = 1'b0;
    full_addr = '0;
    nbits = '0;
    nw = '0;
    s_d.cs_s   = {s_q.cs_s[0], cs_n};
    s_d.sck_s  = {s_q.sck_s[0], sck};
    s_d.si_s   = {s_q.si_s[0], si};
    s_d.so_s   = {s_q.so_s[0], so_in};
    s_d.wp_s   = {s_q.wp_s[0], wp_n};
    s_d.hold_s = {s_q.hold_s[0], hold_n};
    s_d.sck_prev = s_q.sck_s[1];
    s_d.req_valid = 1'b0;
    s_d.req_refused = 1'b0;
    popw = s_q.word_valid & word_ready;

    // Busy timer runs regardless of hold or chip select.
    if (s_q.busy_cnt != 16'h0000) begin // R9
      s_d.busy_cnt = s_q.busy_cnt - 16'h0001;
    end

    if (!cs_act) begin
      // Deselect ends the frame; the next frame restarts at the opcode.
      s_d.st = SFPP_ST_OPC; // R17
      s_d.bits = '0;
      s_d.dual = 1'b0;
      s_d.out_on = 1'b0;
      s_d.so_oe_n = 1'b1; // R3
      // The phase is forced to opcode while deselected, so a data phase seen here
      // can only be the first deselected cycle, that is the closing edge.
      if (s_q.st == SFPP_ST_DATA && s_q.kind != SFPP_OP_NONE_K
          && s_q.kind != SFPP_OP_PROG_K) begin
        // Erase commits only at the closing chip select edge.
        s_d.req.kind = s_q.kind;
        s_d.req.addr = s_q.addr;
        s_d.req_refused = ~s_q.prot_ok; // R12
        s_d.req_valid = s_q.prot_ok;
        if (s_q.prot_ok) s_d.busy_cnt = 16'(BUSY_CYCLES);
      end
    end else if (hold_act) begin
      // Frame state is kept untouched; only the output lets go.
      s_d.so_oe_n = 1'b1; // R6 R7
    end else begin
      // A read paused by hold drives its held bit again as soon as hold lets go.
      if (s_q.out_on) s_d.so_oe_n = 1'b0; // R7
      if (rise) begin
        s_d.sh = s_q.dual ? {s_q.sh[5:0], s_q.so_s[1], s_q.si_s[1]} // R2
                          : {s_q.sh[6:0], s_q.si_s[1]}; // R16
        nbits = 9'(s_q.bits) + (s_q.dual ? 9'd2 : 9'd1);
        s_d.bits = nbits[5:0];
        bitv = 1'b1;
      end
      unique case (s_q.st)
        SFPP_ST_OPC: if (bitv && s_d.bits == SFPP_OPC_BITS) begin
          s_d.opc = s_d.sh;
          s_d.kind = SFPP_OP_NONE_K;
          s_d.st = SFPP_ST_ADDR;
          unique case (s_d.sh)
            SFPP_OP_PROGRAM, SFPP_OP_DUAL_PROGRAM: s_d.kind = SFPP_OP_PROG_K; // R14
            SFPP_OP_ERASE_4K:   s_d.kind = SFPP_OP_E4K_K;   // R13
            SFPP_OP_ERASE_32K:  s_d.kind = SFPP_OP_E32K_K;  // R13
            SFPP_OP_ERASE_64K:  s_d.kind = SFPP_OP_E64K_K;  // R13
            SFPP_OP_ERASE_CHIP: begin
              s_d.kind = SFPP_OP_ECHIP_K; // R11
              s_d.st = SFPP_ST_DATA;
              s_d.prot_ok = ~wp_act && (sector_protect == '0); // R4 R12
            end
            SFPP_OP_READ: s_d.kind = SFPP_OP_NONE_K;
            default: s_d.st = SFPP_ST_SKIP;
          endcase
        end
        SFPP_ST_ADDR: if (bitv && s_d.bits[2:0] == 3'b000) begin
          s_d.addr = {s_q.addr[15:0], s_d.sh};
          if (s_d.bits == SFPP_ADDR_END) begin
            full_addr = s_d.addr;
            s_d.st = SFPP_ST_DATA;
            s_d.bits = '0;
            s_d.dual = (s_q.opc == SFPP_OP_DUAL_PROGRAM); // R2
            unique case (s_q.kind)
              SFPP_OP_E4K_K:  s_d.addr = align(full_addr, SFPP_BLK4_LSB);   // R18
              SFPP_OP_E32K_K: s_d.addr = align(full_addr, SFPP_BLK32_LSB);  // R18
              SFPP_OP_E64K_K: s_d.addr = align(full_addr, SFPP_SECTOR_LSB); // R18
              default: s_d.addr = full_addr;
            endcase
            // Locked sector with write-protect asserted refuses change.
            s_d.prot_ok = ~(wp_act & sector_protect[sector_of(full_addr)]); // R4 R12
            s_d.out_sh = read_data;
          end
        end
        SFPP_ST_DATA: begin
          if (bitv && s_d.bits == SFPP_OPC_BITS) begin
            s_d.bits = '0;
            if (s_q.kind == SFPP_OP_PROG_K && s_q.prot_ok && s_q.count != 2'd2) begin
              pushw = 1'b1;
              nw.addr = s_q.addr;
              nw.data = s_d.sh;
            end else if (s_q.kind == SFPP_OP_PROG_K && !s_q.prot_ok) begin
              s_d.req_refused = 1'b1; // R12
            end
            // Page wrap keeps a program inside one 256-byte page.
            s_d.addr[SFPP_PAGE_LSB-1:0] = s_q.addr[SFPP_PAGE_LSB-1:0] + 8'h01; // R14
          end
          if (s_q.kind == SFPP_OP_NONE_K && fall) begin
            s_d.so_out = s_q.out_sh[7]; // R1
            s_d.out_sh = {s_q.out_sh[6:0], s_q.out_sh[7]};
            s_d.so_oe_n = 1'b0;
            s_d.out_on = 1'b1;
          end
        end
        SFPP_ST_SKIP: ;
      endcase
    end

    // Busy follows the counter after a new erase has loaded it, so it rises with the request.
    s_d.busy = (s_d.busy_cnt != 16'h0000); // R9

    // Two-entry buffer between the frame and the array engine.
    if (pushw) begin
      s_d.fifo[s_q.wptr[0]] = nw;
      s_d.wptr = s_q.wptr + 2'd1;
    end
    if (popw) s_d.rptr = s_q.rptr + 2'd1;
    s_d.count = s_q.count + {1'b0, pushw} - {1'b0, popw};
    if (popw || !s_q.word_valid) begin
      s_d.word_valid = (s_d.count != 2'd0);
      s_d.word = s_d.fifo[s_d.rptr[0]];
    end
  end

  // State register; synchronisers reset to the idle pin levels.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '{cs_s: 2'b11, sck_s: 2'b00, si_s: 2'b00, so_s: 2'b00, wp_s: 2'b11,
               hold_s: 2'b11, so_oe_n: 1'b1, st: SFPP_ST_OPC, kind: SFPP_OP_NONE_K,
               default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  assign so_out      = s_q.so_out;
  assign so_oe_n     = s_q.so_oe_n;
  assign req         = s_q.req;
  assign req_valid   = s_q.req_valid;
  assign req_refused = s_q.req_refused;
  assign word        = s_q.word;
  assign word_valid  = s_q.word_valid;
  assign busy        = s_q.busy;

  // Output released one cycle after synchronised deselect.
  property p_cs_float;
    @(posedge clk) disable iff (!rst_n) s_q.cs_s[1] |=> so_oe_n;
  endproperty
  a_cs_float: assert property (p_cs_float) else $error("Output driven while deselected."); // R3

  property p_hold_float;
    @(posedge clk) disable iff (!rst_n) (cs_act && hold_act) |=> so_oe_n;
  endproperty
  a_hold_float: assert property (p_hold_float) else $error("Output driven during hold."); // R6

  property p_hold_keeps;
    @(posedge clk) disable iff (!rst_n)
      (cs_act && hold_act) |=> ($stable(s_q.bits) && $stable(s_q.st));
  endproperty
  a_hold_keeps: assert property (p_hold_keeps) else $error("Frame state moved in hold."); // R7

  property p_busy_runs;
    @(posedge clk) disable iff (!rst_n) (s_q.busy_cnt > 16'd1) |=> s_q.busy;
  endproperty
  a_busy_runs: assert property (p_busy_runs) else $error("Busy dropped early."); // R9

  property p_refuse;
    @(posedge clk) disable iff (!rst_n) req_refused |-> (!req_valid && !$past(s_q.prot_ok));
  endproperty
  a_refuse: assert property (p_refuse) else $error("Request both taken and refused."); // R12

  property p_out_fall;
    @(posedge clk) disable iff (!rst_n) $changed(so_out) |-> $past(fall);
  endproperty
  a_out_fall: assert property (p_out_fall) else $error("Output moved without falling edge."); // R1

  property p_fifo_cap;
    @(posedge clk) disable iff (!rst_n) s_q.count <= 2'd2;
  endproperty
  a_fifo_cap: assert property (p_fifo_cap) else $error("Buffer overfilled.");

  property p_align64;
    @(posedge clk) disable iff (!rst_n)
      (req_valid && req.kind == SFPP_OP_E64K_K) |-> (req.addr[15:0] == 16'h0000);
  endproperty
  a_align64: assert property (p_align64) else $error("64K erase not aligned."); // R18

  property p_frame;
    @(posedge clk) disable iff (!rst_n) s_q.cs_s[1] |=> (s_q.st == SFPP_ST_OPC);
  endproperty
  a_frame: assert property (p_frame) else $error("Frame survived deselect."); // R17

endmodule : sfpp_device
`default_nettype wire

/* logic/sfpp_pkg.sv */
// Package for the serial flash pin protocol block: opcodes, array geometry, carriers.
package sfpp_pkg;

  // Command opcodes decoded by the pin front end.
  localparam logic [7:0] SFPP_OP_PROGRAM      = 8'h02;
  localparam logic [7:0] SFPP_OP_DUAL_PROGRAM = 8'hA2;
  localparam logic [7:0] SFPP_OP_ERASE_4K     = 8'h20;
  localparam logic [7:0] SFPP_OP_ERASE_32K    = 8'h52;
  localparam logic [7:0] SFPP_OP_ERASE_64K    = 8'hD8;
  localparam logic [7:0] SFPP_OP_ERASE_CHIP   = 8'hC7;
  localparam logic [7:0] SFPP_OP_READ         = 8'h03;

  // Array geometry as address bit positions, plus address width, sector count and page size.
  localparam int SFPP_ADDR_BITS   = 24;
  localparam int SFPP_SECTOR_LSB  = 16;
  localparam int SFPP_SECTORS     = 64;
  localparam int SFPP_BLK32_LSB   = 15;
  localparam int SFPP_BLK4_LSB    = 12;
  localparam int SFPP_PAGE_LSB    = 8;
  localparam int SFPP_PAGE_BYTES  = 256;

  // Frame bit counts.
  localparam logic [5:0] SFPP_OPC_BITS  = 6'h08;
  localparam logic [5:0] SFPP_ADDR_END  = 6'h20;

  // Request kind codes: none, program and the four erase granularities.
  typedef enum logic [2:0] {
    SFPP_OP_NONE_K  = 3'b000,
    SFPP_OP_PROG_K  = 3'b001,
    SFPP_OP_E4K_K   = 3'b010,
    SFPP_OP_E32K_K  = 3'b011,
    SFPP_OP_E64K_K  = 3'b100,
    SFPP_OP_ECHIP_K = 3'b101
  } sfpp_kind_type;

  // Frame phases.
  typedef enum logic [1:0] {
    SFPP_ST_OPC  = 2'b00,
    SFPP_ST_ADDR = 2'b01,
    SFPP_ST_DATA = 2'b10,
    SFPP_ST_SKIP = 2'b11
  } sfpp_state_type;

  // Request handed to the array engine.
  typedef struct packed {
    sfpp_kind_type kind;
    logic [23:0]   addr;
  } sfpp_req_type;

  // Program data word with its array address.
  typedef struct packed {
    logic [23:0] addr;
    logic [7:0]  data;
  } sfpp_word_type;

endpackage : sfpp_pkg

/* bench/sfpp_host_model.sv */
// Behavioural serial host that frames commands for the flash pin front end.
`timescale 1ns/1ps
`default_nettype none
module sfpp_host_model (
  input  wire logic clk,
  input  wire logic so_line,
  output logic      cs_n,
  output logic      sck,
  output logic      si,
  output logic      so_drv,
  output logic      so_en,
  output logic      hold_n
);
  // Idle pins: deselected, clock parked low, no hold.
  initial begin
    cs_n   = 1'b1;
    sck    = 1'b0;
    si     = 1'b0;
    so_drv = 1'b0;
    so_en  = 1'b0;
    hold_n = 1'b1;
  end

  // Eight system clocks per half period keeps the link near 125 ns.
  task automatic half();
    repeat (8) @(posedge clk);
  endtask

  // Every operation opens with a falling chip select.
  task automatic frame_start();
    @(posedge clk);
    cs_n <= 1'b0;
    half();
  endtask

  // Closing edge; the line is then left toggling so stale data never looks valid.
  task automatic frame_end();
    half();
    cs_n  <= 1'b1;
    si    <= ~si;
    so_en <= 1'b0;
    half();
  endtask

  // One byte MSB first; dual mode puts the upper bit of each pair on the output line.
  task automatic xfer(input logic [7:0] b, input bit dual, output logic [7:0] r);
    int n;
    n = dual ? 4 : 8;
    for (int i = n - 1; i >= 0; i--) begin
      if (dual) begin
        so_drv <= b[2*i+1];
        so_en  <= 1'b1;
        si     <= b[2*i];
      end else begin
        si <= b[i];
      end
      half();
      sck <= 1'b1;
      r   = {r[6:0], so_line};
      half();
      sck <= 1'b0;
    end
  endtask

  // Hold is only entered while selected and with the clock low.
  task automatic hold_set(input logic lvl);
    @(posedge clk);
    hold_n <= lvl;
    half();
  endtask

  // Clock pulses with junk data that a paused device must not take in.
  task automatic junk_clocks();
    repeat (4) begin
      si <= ~si;
      half();
      sck <= 1'b1;
      half();
      sck <= 1'b0;
    end
  endtask
endmodule // sfpp_host_model
`default_nettype wire

/* bench/serial_flash_pin_protocol_test.sv */
// Self-checking bench for the serial flash pin front end with its host model.
`timescale 1ns/1ps
`default_nettype none
module serial_flash_pin_protocol_test
  import sfpp_pkg::*;
;
  logic clk = 1'b0, rst_n = 1'b0, wp_n = 1'b1, word_ready = 1'b0, pat = 1'b0;
  logic [63:0] sector_protect = 64'h0000_0000_0000_0000;
  logic [7:0] read_data = 8'h00, r;
  wire logic cs_n, sck, si, so_drv, so_en, hold_n, so_in;
  logic so_out, so_oe_n, req_valid, req_refused, word_valid, busy;
  sfpp_req_type req, last_req;
  sfpp_word_type word;
  sfpp_word_type wq[$];
  int num_errors = 0, num_checks = 0, n_req = 0, n_ref = 0, cycles = 0;

  always #4 clk = ~clk;

  // Wire level: device, then host, else a toggling pattern since the line has no pull.
  assign so_in = !so_oe_n ? so_out : (so_en ? so_drv : pat);

  sfpp_host_model host (.clk(clk), .so_line(so_in), .cs_n(cs_n), .sck(sck), .si(si),
    .so_drv(so_drv), .so_en(so_en), .hold_n(hold_n));

  sfpp_device #(.BUSY_CYCLES(16)) dut (.clk(clk), .rst_n(rst_n), .cs_n(cs_n), .sck(sck),
    .si(si), .so_in(so_in), .so_out(so_out), .so_oe_n(so_oe_n), .wp_n(wp_n),
    .hold_n(hold_n), .sector_protect(sector_protect), .read_data(read_data), .req(req),
    .req_valid(req_valid), .req_refused(req_refused), .word(word),
    .word_valid(word_valid), .word_ready(word_ready), .busy(busy));

  // Monitors collect requests, refusals and accepted words; the watchdog cuts hangs.
  always @(posedge clk) begin
    pat <= ~pat;
    cycles++;
    if (req_valid === 1'b1) begin
      last_req = req;
      n_req++;
    end
    if (req_refused === 1'b1) n_ref++;
    if (word_valid === 1'b1 && word_ready === 1'b1) wq.push_back(word);
    if (cycles == 40000) begin
      num_errors++;
      report_and_stop();
    end
  end

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Opcode plus 24-bit address, MSB first.
  task automatic cmd(input logic [7:0] op, input logic [23:0] a);
    host.xfer(op, 0, r);
    for (int i = 2; i >= 0; i--) host.xfer(a[8*i +: 8], 0, r);
  endtask

  task automatic erase(input logic [7:0] op, input logic [23:0] a);
    host.frame_start();
    cmd(op, a);
    host.frame_end();
    repeat (200) if (busy === 1'b1) @(posedge clk);
  endtask

  task automatic t_erase();
    logic [7:0] ops [4] = '{SFPP_OP_ERASE_4K, SFPP_OP_ERASE_32K, SFPP_OP_ERASE_64K,
                            SFPP_OP_ERASE_CHIP};
    sfpp_kind_type kinds [4] = '{SFPP_OP_E4K_K, SFPP_OP_E32K_K, SFPP_OP_E64K_K,
                                 SFPP_OP_ECHIP_K};
    int lsb [4] = '{12, 15, 16, 24};
    int n0;
    for (int k = 0; k < 4; k++) begin
      n0 = n_req;
      host.frame_start();
      cmd(ops[k], 24'h3E_7A5C);
      host.frame_end();
      check("erase count", n0 + 1, n_req);
      check("erase kind", kinds[k], last_req.kind);
      if (lsb[k] < 24) begin
        check("erase addr", 24'h3E_7A5C >> lsb[k] << lsb[k], last_req.addr);
      end
      check("busy", 1'b1, busy);
      repeat (200) if (busy === 1'b1) @(posedge clk);
      check("busy over", 1'b0, busy);
    end
    $display("test erase done");
  endtask

  task automatic t_protect();
    int n0, f0;
    n0 = n_req;
    f0 = n_ref;
    sector_protect <= 64'h8000_0000_0000_0000;
    wp_n <= 1'b0;
    erase(SFPP_OP_ERASE_64K, 24'h3F_0000);
    check("refused top sector", f0 + 1, n_ref);
    check("no request", n0, n_req);
    erase(SFPP_OP_ERASE_64K, 24'h3E_0000);
    check("neighbour sector", n0 + 1, n_req);
    host.frame_start();
    cmd(SFPP_OP_PROGRAM, 24'h3F_0010);
    host.xfer(8'h55, 0, r);
    host.frame_end();
    check("program refused", f0 + 2, n_ref);
    check("no word", 1'b0, word_valid);
    erase(SFPP_OP_ERASE_CHIP, 24'h00_0000);
    check("chip refused", f0 + 3, n_ref);
    check("no chip request", n0 + 1, n_req);
    wp_n <= 1'b1;
    erase(SFPP_OP_ERASE_64K, 24'h3F_0000);
    check("lock released", n0 + 2, n_req);
    check("refusals", f0 + 3, n_ref);
    sector_protect <= 64'h0000_0000_0000_0000;
    $display("test protect done");
  endtask

  task automatic t_program();
    wq.delete();
    word_ready <= 1'b0;
    host.frame_start();
    cmd(SFPP_OP_PROGRAM, 24'h00_12FF);
    host.hold_set(1'b0);
    check("out off in hold", 1'b1, so_oe_n);
    host.junk_clocks();
    host.hold_set(1'b1);
    host.xfer(8'hA1, 0, r);
    host.xfer(8'hA2, 0, r);
    host.xfer(8'hA3, 0, r);
    host.frame_end();
    check("stalled", 0, wq.size());
    word_ready <= 1'b1;
    repeat (10) @(posedge clk);
    check("kept words", 2, wq.size());
    check("word 0", {24'h00_12FF, 8'hA1}, wq[0]);
    check("word 1 wraps", {24'h00_1200, 8'hA2}, wq[1]);
    $display("test program done");
  endtask

  task automatic t_dual();
    wq.delete();
    host.frame_start();
    cmd(SFPP_OP_DUAL_PROGRAM, 24'h00_0100);
    host.xfer(8'hB4, 1, r);
    host.frame_end();
    check("dual count", 1, wq.size());
    check("dual word", {24'h00_0100, 8'hB4}, wq[0]);
    $display("test dual done");
  endtask

  task automatic t_read();
    read_data <= 8'h5A;
    host.frame_start();
    cmd(SFPP_OP_READ, 24'h00_0000);
    host.xfer(8'h00, 0, r);
    check("read byte", 8'h5A, r);
    host.hold_set(1'b0);
    check("read off in hold", 1'b1, so_oe_n);
    host.junk_clocks();
    host.hold_set(1'b1);
    check("read resumes", 1'b0, so_oe_n);
    host.xfer(8'hFF, 0, r);
    check("read again", 8'h5A, r);
    host.frame_end();
    check("out off deselected", 1'b1, so_oe_n);
    $display("test read done");
  endtask

  // Reset, then each scenario in turn.
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    check("idle out off", 1'b1, so_oe_n);
    t_erase();
    t_protect();
    t_program();
    t_dual();
    t_read();
    report_and_stop();
  end
endmodule // serial_flash_pin_protocol_test
`default_nettype wire
